// ---- hw/tsm_defines.svh ----
`ifndef TSM_DEFINES_SVH
`define TSM_DEFINES_SVH

// System clock rate in MHz
`define TSM_CLK_MHZ 125
// One millisecond expressed in microseconds
`define TSM_MS_US 1000
// Clock cycles in one millisecond, derived from the two figures above
`define TSM_MS_CYC (`TSM_MS_US * `TSM_CLK_MHZ)
// Width of the millisecond divider
`define TSM_DIV_W 17

// Shortest scan period the timer will run, in ms
`define TSM_SCAN_MIN_MS 11'h00F
// Boot scan periods in ms
`define TSM_ACTIVE_MS 11'h01E
`define TSM_DOZE_MS 11'h0C3
// Boot idle timeout in ms, zero switches it off
`define TSM_IDLE_MS 16'h1388
// Boot fade settings
`define TSM_FADE_STEP_MS 8'h04
`define TSM_FADE_INIT 8'h00
`define TSM_FADE_FINAL 8'hFF
// Shift that sets the logarithmic fade step
`define TSM_LOG_SHIFT 3
// Index of the last capacitive input
`define TSM_LAST_CH 3'h7

`endif

// ---- hw/tsm_pkg.sv ----
package tsm_pkg;

  // Operating modes, Gray along Active, Doze, Sleep
  typedef enum logic [1:0] {
    MD_ACTIVE = 2'h0,
    MD_DOZE   = 2'h1,
    MD_SLEEP  = 2'h3
  } tsm_mode_e;

  // Scan phases, Gray along sense, process, timer
  typedef enum logic [1:0] {
    PH_SENSE = 2'h0,
    PH_PROC  = 2'h1,
    PH_TIMER = 2'h3,
    PH_SLEEP = 2'h2
  } tsm_phase_e;

  // Parameter set, booted from non-volatile memory
  typedef struct packed {
    logic [10:0]     active_ms;
    logic [10:0]     doze_ms;
    logic [15:0]     idle_ms;
    logic [7:0]      sense_en;
    logic            auto_light;
    logic            wake_en;
    logic [1:0]      wake_last;
    logic [3:0][2:0] wake_seq;
    logic            fade_log;
    logic [7:0]      fade_step_ms;
    logic [7:0]      fade_init;
    logic [7:0]      fade_final;
  } tsm_cfg_s;

  // Scan controller state
  typedef struct packed {
    tsm_phase_e  phase;
    tsm_mode_e   mode;
    logic [2:0]  chan;
    logic [7:0]  acc;
    logic [7:0]  touch;
    logic [7:0]  digital_input_mode;
    logic [7:0]  led_on;
    logic [1:0]  seg;
    logic [16:0] div;
    logic [10:0] ms_cnt;
    logic [15:0] idle_cnt;
    logic [1:0]  wake_idx;
    logic        irq;
    tsm_cfg_s    cfg;
  } tsm_state_s;

  // One fade and PWM channel
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] step_cnt;
    logic [7:0] pwm_cnt;
    logic       pwm;
  } tsm_fade_s;

endpackage : tsm_pkg

// ---- hw/tsm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pin levels
module tsm_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  // Levels in and out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [1:0][W-1:0] pipe;  // Stage 0 is read only by stage 1

  // Plain shift, no logic between the stages
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pipe <= '0;
    end else begin
      pipe <= {pipe[0], d_in};
    end
  end

  assign q_out = pipe[1];

endmodule : tsm_sync

`default_nettype wire

// ---- hw/tsm_fade.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defines.svh"

// One 256-step PWM channel with linear or logarithmic fading
module tsm_fade (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       ms_tick_in,
  // Fade control
  input  wire logic       target_on_in,
  input  wire logic       fade_log_in,
  input  wire logic [7:0] step_ms_in,
  input  wire logic [7:0] init_in,
  input  wire logic [7:0] final_in,
  // Direct host duty
  input  wire logic       host_pwm_in,
  input  wire logic [7:0] host_duty_in,
  // Pin drive
  output logic            pwm_out
);
  import tsm_pkg::*;

  tsm_fade_s s;       // Registered state
  tsm_fade_s next_s;  // Next state

  // Fade toward the target and compare against the free counter
  always_comb begin
    logic [7:0] tgt;
    logic [7:0] delta;
    tgt = target_on_in ? final_in : init_in;
    delta = fade_log_in ? (s.level >> `TSM_LOG_SHIFT) + 8'h01 : 8'h01;
    next_s = s;
    next_s.pwm_cnt = s.pwm_cnt + 8'h01;  // 256 steps per PWM frame
    next_s.pwm = s.pwm_cnt < s.level;
    if (host_pwm_in) begin
      // Host owns the duty, no fading at all
      next_s.level = host_duty_in;
      next_s.step_cnt = 8'h00;
    end else if (ms_tick_in) begin
      if (s.step_cnt >= step_ms_in) begin
        next_s.step_cnt = 8'h00;
        // Clamp at the target so a large log step never overshoots
        if (s.level < tgt) begin
          next_s.level = (tgt - s.level <= delta) ? tgt : s.level + delta;
        end else if (s.level > tgt) begin
          next_s.level = (s.level - tgt <= delta) ? tgt : s.level - delta;
        end
      end else begin
        next_s.step_cnt = s.step_cnt + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pwm_out = s.pwm;

endmodule : tsm_fade

`default_nettype wire

// ---- hw/tsm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defines.svh"

module tsm_ctrl #(
  parameter int                 CYC_PER_MS = `TSM_MS_CYC,  // Shorten for simulation
  parameter tsm_pkg::tsm_cfg_s  NVM_CFG    = '{
    active_ms:    `TSM_ACTIVE_MS,
    doze_ms:      `TSM_DOZE_MS,
    idle_ms:      `TSM_IDLE_MS,
    sense_en:     8'hFF,
    auto_light:   1'b1,
    wake_en:      1'b0,
    wake_last:    2'h0,
    wake_seq:     12'h000,
    fade_log:     1'b1,
    fade_step_ms: `TSM_FADE_STEP_MS,
    fade_init:    `TSM_FADE_INIT,
    fade_final:   `TSM_FADE_FINAL
  }
) (
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   soft_reset_in,
  // Parameter overwrite
  input  wire logic                   cfg_wr_in,
  input  wire tsm_pkg::tsm_cfg_s      cfg_in,
  output tsm_pkg::tsm_cfg_s           cfg_out,
  // Host mode forcing
  input  wire logic                   force_en_in,
  input  wire tsm_pkg::tsm_mode_e     operating_mode_select_in,
  // Charge to tick front end
  output logic                        meas_req_out,
  output logic       [2:0]            meas_sel_out,
  input  wire logic                   meas_done_in,
  input  wire logic                   meas_touch_in,
  // GPIO control
  input  wire logic  [7:0]            host_gpo_in,
  input  wire logic  [7:0]            host_pwm_mode_in,
  input  wire logic  [7:0][7:0]       host_duty_in,
  input  wire logic  [7:0]            digital_input_mode_in,
  // GPIO pins
  input  wire logic  [7:0]            gpio_pin_in,
  output logic       [7:0]            gpio_out,
  output logic       [7:0]            gpio_oe_out,
  // Host status
  input  wire logic                   irq_ack_in,
  output logic                        irq_n_out,
  output logic       [7:0]            touch_status_out,
  output logic       [7:0]            gpi_status_out,
  output logic       [1:0]            wheel_seg_out,
  output tsm_pkg::tsm_mode_e          mode_out,
  output tsm_pkg::tsm_phase_e         phase_out
);
  import tsm_pkg::*;

  // Divider width must hold one millisecond
  if (CYC_PER_MS < 2 || CYC_PER_MS > (1 << `TSM_DIV_W)) begin : g_chk
    $error("CYC_PER_MS out of range");
  end

  localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);  // Last divider count

  // Reset image, parameters as loaded at boot
  localparam tsm_state_s ST_RST = '{
    phase: PH_SENSE, mode: MD_ACTIVE, cfg: NVM_CFG, default: '0
  };

  tsm_state_s  s;        // Registered state
  tsm_state_s  next_s;   // Next state
  logic [7:0]  pin_q;    // Synchronised GPIO levels
  logic [7:0]  pwm;      // Per-pin PWM outputs
  logic        ms_tick;  // One-cycle pulse each ms
  logic [10:0] per;      // Scan period in force, ms

  // GPIO pins come from outside the clock domain
  tsm_sync #(.W(8)) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .d_in       (gpio_pin_in),
    .q_out      (pin_q)
  );

  assign ms_tick = (s.div == MS_LAST);

  // Period follows the mode; clamped so the scan never runs too fast
  always_comb begin
    per = (s.mode == MD_DOZE) ? s.cfg.doze_ms : s.cfg.active_ms;
    if (per < `TSM_SCAN_MIN_MS) begin
      per = `TSM_SCAN_MIN_MS;
    end
  end

  // Front end request only for an enabled input while sensing
  assign meas_req_out = (s.phase == PH_SENSE) && s.cfg.sense_en[s.chan];
  assign meas_sel_out = s.chan;

  // Scan sequencer, mode control and status
  always_comb begin
    logic [7:0] tch;
    logic [7:0] rel;
    logic [7:0] gpi_now;
    logic       seg_vld;
    logic [1:0] seg;
    tsm_mode_e  nm;
    logic       irq_evt;  // New interrupt cause this cycle
    irq_evt = 1'b0;
    tch = s.acc & ~s.touch;
    rel = s.touch & ~s.acc;
    gpi_now = pin_q & digital_input_mode_in;
    seg_vld = 1'b0;
    seg = s.seg;
    nm = s.mode;
    next_s = s;
    next_s.div = ms_tick ? 17'h00000 : s.div + 17'h00001;
    // Wheel segment is the lowest touched of the upper four inputs
    for (int i = 7; i >= 4; i--) begin
      if (s.acc[i]) begin
        seg_vld = 1'b1;
        seg = 2'(i - 4);
      end
    end
    // Idle time accumulates only while Active
    if (ms_tick && s.mode == MD_ACTIVE && s.idle_cnt != 16'hFFFF) begin
      next_s.idle_cnt = s.idle_cnt + 16'h0001;
    end
    if (ms_tick && s.ms_cnt != 11'h7FF && s.phase != PH_SLEEP) begin
      next_s.ms_cnt = s.ms_cnt + 11'h001;
    end
    case (s.phase)
      PH_SENSE: begin
        // Disabled inputs pass at once, enabled ones wait for the front end
        if (!s.cfg.sense_en[s.chan] || meas_done_in) begin
          next_s.acc[s.chan] = s.cfg.sense_en[s.chan] & meas_touch_in;
          if (s.chan == `TSM_LAST_CH) begin
            next_s.phase = PH_PROC;
          end else begin
            next_s.chan = s.chan + 3'h1;
          end
        end
      end
      PH_PROC: begin
        // Touch, wheel and LED state are committed only here; sleep also updates GPI status, interrupt and mode
        next_s.touch = s.acc;
        next_s.digital_input_mode = gpi_now;
        next_s.seg = seg;
        if (s.acc != s.touch || gpi_now != s.digital_input_mode) begin
          next_s.irq = 1'b1;
          irq_evt = 1'b1;
        end
        if (s.cfg.auto_light) begin
          next_s.led_on = {4'h0, s.acc[3:0]};
          if (seg_vld) begin
            next_s.led_on[3'(4 + seg)] = 1'b1;
          end
        end else begin
          next_s.led_on = host_gpo_in;
        end
        if (|s.acc) begin
          next_s.idle_cnt = 16'h0000;
        end
        // Mode decided once per scan, used by the timer wait of this same scan
        if (force_en_in) begin
          nm = operating_mode_select_in;
        end else begin
          case (s.mode)
            MD_ACTIVE: begin
              if (s.cfg.idle_ms != 16'h0000 && s.idle_cnt >= s.cfg.idle_ms && s.acc == 8'h00) begin
                nm = MD_DOZE;
              end
            end
            MD_DOZE: begin
              if (!s.cfg.wake_en) begin
                if (|tch) begin
                  nm = MD_ACTIVE;
                end
              end else if (|rel) begin
                // A wrong release restarts the sequence
                if (rel == (8'h01 << s.cfg.wake_seq[s.wake_idx])) begin
                  if (s.wake_idx == s.cfg.wake_last) begin
                    nm = MD_ACTIVE;
                    next_s.wake_idx = 2'h0;
                  end else begin
                    next_s.wake_idx = s.wake_idx + 2'h1;
                  end
                end else begin
                  next_s.wake_idx = 2'h0;
                end
              end
            end
            default: begin
              nm = MD_ACTIVE;
            end
          endcase
        end
        if (nm == MD_ACTIVE && s.mode != MD_ACTIVE) begin
          next_s.idle_cnt = 16'h0000;
        end
        if (nm != MD_DOZE) begin
          next_s.wake_idx = 2'h0;
        end
        next_s.mode = nm;
        next_s.phase = (nm == MD_SLEEP) ? PH_SLEEP : PH_TIMER;
      end
      PH_TIMER: begin
        // Low power wait until the whole period has run
        if (s.ms_cnt >= per) begin
          next_s.phase = PH_SENSE;
          next_s.ms_cnt = 11'h000;
          next_s.chan = 3'h0;
          next_s.acc = 8'h00;
        end
      end
      default: begin
        // Sleep: no scanning, digital inputs still watched each ms
        if (ms_tick && gpi_now != s.digital_input_mode) begin
          next_s.digital_input_mode = gpi_now;
          next_s.irq = 1'b1;
          irq_evt = 1'b1;
        end
        if (!(force_en_in && operating_mode_select_in == MD_SLEEP)) begin
          next_s.mode = force_en_in ? operating_mode_select_in : MD_ACTIVE;
          next_s.phase = PH_SENSE;
          next_s.ms_cnt = 11'h000;
          next_s.chan = 3'h0;
          next_s.acc = 8'h00;
          next_s.idle_cnt = 16'h0000;
        end
      end
    endcase
    // Acknowledge loses to a new event in the same cycle
    if (irq_ack_in && !irq_evt) begin
      next_s.irq = 1'b0;
    end
    if (cfg_wr_in) begin
      next_s.cfg = cfg_in;
    end
    if (soft_reset_in) begin
      next_s = ST_RST;
    end
  end

  // State register; reset reloads the boot parameters
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // One fade generator per pin
  for (genvar g = 0; g < 8; g++) begin : g_pwm
    tsm_fade u_fade (
      .clk_sys_in   (clk_sys_in),
      .rst_n_in     (rst_n_in),
      .ms_tick_in   (ms_tick),
      .target_on_in (s.led_on[g]),
      .fade_log_in  (s.cfg.fade_log),
      .step_ms_in   (s.cfg.fade_step_ms),
      .init_in      (s.cfg.fade_init),
      .final_in     (s.cfg.fade_final),
      .host_pwm_in  (host_pwm_mode_in[g]),
      .host_duty_in (host_duty_in[g]),
      .pwm_out      (pwm[g])
    );
  end

  // Outputs
  assign gpio_out         = pwm;
  assign gpio_oe_out      = ~digital_input_mode_in;
  assign irq_n_out        = ~s.irq;
  assign touch_status_out = s.touch;
  assign gpi_status_out   = s.digital_input_mode;
  assign wheel_seg_out    = s.seg;
  assign mode_out         = s.mode;
  assign phase_out        = s.phase;
  assign cfg_out          = s.cfg;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sense_order_a: assert property (
    (s.phase == PH_SENSE && s.chan != 3'h7 && !soft_reset_in
     && (meas_done_in || !s.cfg.sense_en[s.chan]))
    |=> s.chan == $past(s.chan) + 3'h1)
    else $error("sense order broken");
  proc_next_a: assert property (
    (s.phase == PH_PROC && !soft_reset_in) |=> s.phase inside {PH_TIMER, PH_SLEEP})
    else $error("processing not followed by timer");
  timer_wait_a: assert property (
    (s.phase == PH_TIMER && s.ms_cnt < per && !soft_reset_in) |=> s.phase == PH_TIMER)
    else $error("timer left early");
  period_sel_a: assert property (
    (s.mode == MD_DOZE && s.cfg.doze_ms >= `TSM_SCAN_MIN_MS) |-> per == s.cfg.doze_ms)
    else $error("doze period not used");
  status_hold_a: assert property (
    (s.phase != PH_PROC && !soft_reset_in) |=> $stable(touch_status_out))
    else $error("status changed outside processing");
  irq_set_a: assert property (
    (s.phase == PH_PROC && s.acc != s.touch && !soft_reset_in) |=> !irq_n_out)
    else $error("interrupt not raised");
  sleep_idle_a: assert property (
    s.phase == PH_SLEEP |-> !meas_req_out)
    else $error("scanning in sleep");
  idle_doze_a: assert property (
    (s.phase == PH_PROC && !force_en_in && !soft_reset_in && s.mode == MD_ACTIVE
     && s.cfg.idle_ms != 16'h0000 && s.idle_cnt >= s.cfg.idle_ms && s.acc == 8'h00)
    |=> s.mode == MD_DOZE)
    else $error("idle timeout missed");
  wake_touch_a: assert property (
    (s.phase == PH_PROC && !force_en_in && !soft_reset_in && s.mode == MD_DOZE
     && !s.cfg.wake_en && (s.acc & ~s.touch) != 8'h00)
    |=> s.mode == MD_ACTIVE && s.phase == PH_TIMER)
    else $error("touch did not wake");
  force_mode_a: assert property (
    (s.phase == PH_PROC && force_en_in && !soft_reset_in)
    |=> s.mode == $past(operating_mode_select_in))
    else $error("forced mode ignored");

endmodule : tsm_ctrl

`default_nettype wire

// ---- sim/tsm_frontend_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Charge to tick front end: answers each request after a set delay
module tsm_frontend_model (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Request from the block
  input  wire logic       meas_req_in,
  input  wire logic [2:0] meas_sel_in,
  // Bench stimulus: touched channels and answer delay
  input  wire logic [7:0] touch_map_in,
  input  wire logic [3:0] delay_in,
  // Result back to the block
  output logic            meas_done_out,
  output logic            meas_touch_out
);
  logic [3:0] cnt;  // Cycles spent on the current channel

  // One-cycle result pulse; the touch line toggles between results
  // so a design that samples it outside a result sees no steady value
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt            <= 4'h0;
      meas_done_out  <= 1'b0;
      meas_touch_out <= 1'b0;
    end else if (meas_done_out || !meas_req_in) begin
      // Result taken or no request: start over
      cnt            <= 4'h0;
      meas_done_out  <= 1'b0;
      meas_touch_out <= ~meas_touch_out;
    end else if (cnt >= delay_in) begin
      // Delay spent: report the selected channel
      meas_done_out  <= 1'b1;
      meas_touch_out <= touch_map_in[meas_sel_in];
    end else begin
      cnt            <= cnt + 4'h1;
      meas_touch_out <= ~meas_touch_out;
    end
  end
endmodule : tsm_frontend_model
`default_nettype wire

// ---- sim/tb_tsm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defines.svh"

// Bench for the scan and mode controller
module tb_tsm_ctrl;
  import tsm_pkg::*;
  localparam int MS = 20;  // Short ms keeps doze periods affordable
  // Design and model signals
  logic            clk_sys_in, rst_n_in, soft_reset_in, cfg_wr_in, irq_ack_in;
  logic            force_en_in, meas_req_out, meas_done_in, meas_touch_in, irq_n_out;
  tsm_mode_e       op_sel, mode_out;
  tsm_phase_e      phase_out, last_ph;
  tsm_cfg_s        cfg_in, cfg_out, c0, c;
  logic [2:0]      meas_sel_out;
  logic [1:0]      wheel_seg_out;
  logic [3:0]      dly;
  logic [7:0]      host_gpo_in, pwm_mode, dig_mode, pin_in, gpio_out, gpio_oe_out;
  logic [7:0]      touch_status_out, gpi_status_out, last_ts, touch_map;
  logic [7:0][7:0] duty;
  logic [2:0]      seen_q[$];
  logic [2:0]      exp_ch[4] = '{3'h0, 3'h2, 3'h5, 3'h7};
  int              err_total, tests_run, cyc, n;

  tsm_ctrl #(.CYC_PER_MS(MS)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .soft_reset_in(soft_reset_in),
    .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .cfg_out(cfg_out),
    .force_en_in(force_en_in), .operating_mode_select_in(op_sel),
    .meas_req_out(meas_req_out), .meas_sel_out(meas_sel_out),
    .meas_done_in(meas_done_in), .meas_touch_in(meas_touch_in),
    .host_gpo_in(host_gpo_in), .host_pwm_mode_in(pwm_mode), .host_duty_in(duty),
    .digital_input_mode_in(dig_mode), .gpio_pin_in(pin_in), .gpio_out(gpio_out),
    .gpio_oe_out(gpio_oe_out), .irq_ack_in(irq_ack_in), .irq_n_out(irq_n_out),
    .touch_status_out(touch_status_out), .gpi_status_out(gpi_status_out),
    .wheel_seg_out(wheel_seg_out), .mode_out(mode_out), .phase_out(phase_out));

  tsm_frontend_model fe (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .meas_req_in(meas_req_out),
    .meas_sel_in(meas_sel_out), .touch_map_in(touch_map), .delay_in(dly),
    .meas_done_out(meas_done_in), .meas_touch_out(meas_touch_in));

  // Compare and count; four-state so an unknown never matches
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // Report counts and the verdict, then stop
  task automatic end_sim;
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  // Bounded waits; running out shows up as a mismatch
  task automatic wait_ph(input tsm_phase_e p);
    for (int i = 0; i < 5000 && phase_out !== p; i++) @(negedge clk_sys_in);
    if (phase_out !== p) check(phase_out, p);
  endtask : wait_ph

  task automatic wait_md(input tsm_mode_e m);
    for (int i = 0; i < 9000 && mode_out !== m; i++) @(negedge clk_sys_in);
    check(mode_out, m);
  endtask : wait_md

  // Load a parameter set and read it back
  task automatic set_cfg(input tsm_cfg_s v);
    cfg_in    = v;
    cfg_wr_in = 1'b1;
    @(negedge clk_sys_in);
    cfg_wr_in = 1'b0;
    @(negedge clk_sys_in);
    check(cfg_out, v);
  endtask : set_cfg

  // Whole scan period in ms, from one sensing start to the next
  task automatic period(input logic [31:0] ms);
    int t0;
    wait_ph(PH_TIMER);
    wait_ph(PH_SENSE);
    t0 = cyc;
    wait_ph(PH_TIMER);
    wait_ph(PH_SENSE);
    check((cyc - t0) / MS, ms);
  endtask : period

  // Change touches only while idle so a scan never sees half a change
  task automatic scan(input logic [7:0] map);
    wait_ph(PH_TIMER);
    touch_map = map;
    wait_ph(PH_PROC);
    @(negedge clk_sys_in);
  endtask : scan

  // High cycles of one pin over two PWM frames
  task automatic highs(input int pin, output int k);
    k = 0;
    repeat (512) begin
      @(negedge clk_sys_in);
      k += gpio_out[pin];
    end
  endtask : highs

  task automatic ack;
    irq_ack_in = 1'b1;
    @(negedge clk_sys_in);
    irq_ack_in = 1'b0;
    @(negedge clk_sys_in);
  endtask : ack

  // Clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // Cycle count, hang cut-off and log of measured channels
  always @(posedge clk_sys_in) begin
    if (rst_n_in && meas_req_out && meas_done_in) seen_q.push_back(meas_sel_out);
    cyc++;
    if (cyc == 100000) begin
      err_total++;
      end_sim();
    end
  end

  // Touch status may only move on the edge that closes processing
  always @(negedge clk_sys_in) begin
    if (rst_n_in && touch_status_out !== last_ts) check(last_ph, PH_PROC);
    last_ts <= touch_status_out;
    last_ph <= phase_out;
  end

  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    soft_reset_in = 1'b0;
    cfg_wr_in = 1'b0;
    irq_ack_in = 1'b0;
    force_en_in = 1'b0;
    op_sel = MD_ACTIVE;
    host_gpo_in = 8'h00;
    pwm_mode = 8'h00;
    dig_mode = 8'h00;
    pin_in = 8'h00;
    duty = '0;
    touch_map = 8'h00;
    dly = 4'h6;
    cfg_in = '0;
    c0 = '{active_ms: `TSM_ACTIVE_MS, doze_ms: `TSM_DOZE_MS, idle_ms: `TSM_IDLE_MS,
           sense_en: 8'hFF, auto_light: 1'b1, wake_en: 1'b0, wake_last: 2'h0,
           wake_seq: 12'h000, fade_log: 1'b1, fade_step_ms: `TSM_FADE_STEP_MS,
           fade_init: `TSM_FADE_INIT, fade_final: `TSM_FADE_FINAL};
    repeat (10) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    check(phase_out, PH_SENSE);
    check(mode_out, MD_ACTIVE);
    check(irq_n_out, 1'b1);
    check(cfg_out, c0);
    // Sparse enables with a slow front end
    c = c0;
    c.sense_en = 8'hA5;
    c.idle_ms = 16'h0000;
    set_cfg(c);
    wait_ph(PH_PROC);
    wait_ph(PH_SENSE);
    seen_q.delete();
    wait_ph(PH_PROC);
    check(seen_q.size(), 4);
    foreach (seen_q[i]) check(seen_q[i], exp_ch[i]);
    // Default period, then a request below the floor
    c.sense_en = 8'hFF;
    dly = 4'h1;
    set_cfg(c);
    period(32'h1E);
    c.active_ms = 11'h005;
    set_cfg(c);
    period(32'h0F);
    c.active_ms = `TSM_ACTIVE_MS;
    set_cfg(c);
    // Button 0 and wheel sensor 5 touched together
    scan(8'h21);
    check(irq_n_out, 1'b0);
    check(touch_status_out, 8'h21);
    check(wheel_seg_out, 2'h1);
    repeat (800) @(negedge clk_sys_in);
    highs(0, n);
    check(n > 0, 1'b1);
    highs(5, n);
    check(n > 0, 1'b1);
    highs(3, n);
    check(n, 0);
    ack();
    check(irq_n_out, 1'b1);
    // Release: status clears, LED fades rather than cutting off
    scan(8'h00);
    check(touch_status_out, 8'h00);
    check(irq_n_out, 1'b0);
    highs(0, n);
    check(n > 0, 1'b1);
    // Direct host duty on the two top pins
    pwm_mode = 8'hC0;
    duty[6] = 8'h80;
    highs(6, n);
    check(n >= 240 && n <= 272, 1'b1);
    highs(7, n);
    check(n, 0);
    ack();
    // Host sets the target with auto light off; a linear ramp stays well below a log one
    c.auto_light = 1'b0;
    c.fade_log = 1'b0;
    set_cfg(c);
    wait_ph(PH_TIMER);
    host_gpo_in = 8'h10;
    scan(8'h00);
    repeat (2400) @(negedge clk_sys_in);
    highs(4, n);
    check(n >= 40 && n <= 70, 1'b1);
    // Idle timeout to doze, then a touch wakes
    c.idle_ms = 16'h0028;
    set_cfg(c);
    wait_md(MD_DOZE);
    check(phase_out, PH_TIMER);
    period(32'hC3);
    scan(8'h01);
    wait_md(MD_ACTIVE);
    scan(8'h00);
    // Wake sequence channel 2 then 3; a wrong button restarts it
    c.wake_en = 1'b1;
    c.wake_last = 2'h1;
    c.wake_seq = 12'h01A;
    set_cfg(c);
    wait_md(MD_DOZE);
    scan(8'h04);
    scan(8'h00);
    scan(8'h02);
    scan(8'h00);
    scan(8'h08);
    scan(8'h00);
    check(mode_out, MD_DOZE);
    scan(8'h04);
    scan(8'h00);
    scan(8'h08);
    scan(8'h00);
    wait_md(MD_ACTIVE);
    // Forced sleep: no scanning, digital input still seen
    force_en_in = 1'b1;
    op_sel = MD_SLEEP;
    wait_md(MD_SLEEP);
    @(negedge clk_sys_in);
    check(phase_out, PH_SLEEP);
    seen_q.delete();
    dig_mode = 8'h04;
    pin_in = 8'h04;
    repeat (600) @(negedge clk_sys_in);
    check(seen_q.size(), 0);
    check(meas_req_out, 1'b0);
    check(gpio_oe_out, 8'hFB);
    check(gpi_status_out, 8'h04);
    op_sel = MD_DOZE;
    wait_md(MD_DOZE);
    force_en_in = 1'b0;
    // Soft reset brings back boot parameters and state
    soft_reset_in = 1'b1;
    @(negedge clk_sys_in);
    soft_reset_in = 1'b0;
    check(cfg_out, c0);
    check(mode_out, MD_ACTIVE);
    check(irq_n_out, 1'b1);
    end_sim();
  end
endmodule : tb_tsm_ctrl
`default_nettype wire
